// File: rtl/hwr_pkg.sv
package hwr_pkg;

  // start-up delay, in system clock pulses
  localparam int          SST_CYCLES      = 1024;
  // option-loading delay added to full resets only, in system clock pulses
  localparam int          OPT_LOAD_CYCLES = 16;
  localparam int          CNT_W           = 11;
  localparam logic [10:0] SST_LAST        = 11'(SST_CYCLES - 1);
  localparam logic [10:0] OPT_LAST        = 11'(OPT_LOAD_CYCLES - 1);
  localparam logic [10:0] CNT_ZERO        = 11'h000;

  localparam int          PORT_A_W        = 8;
  localparam int          IRQ_W           = 3;

  // values the core loads while full_reset_out is high
  localparam logic [12:0] PROG_COUNTER_RST     = 13'h0000;
  localparam logic [7:0]  BANK_SELECT_RST      = 8'h00;
  localparam logic [7:0]  WATCHDOG_SCALE_RST   = 8'h07;
  localparam logic [7:0]  IRQ_CONTROL_RST      = 8'h00;
  localparam logic [7:0]  TIMER0_CTRL_RST      = 8'h08;
  localparam logic [7:0]  PORT_A_DATA_RST      = 8'hff;
  localparam logic [7:0]  PORT_A_DIR_RST       = 8'hff;

  typedef enum logic [2:0] {
    ST_PIN  = 3'h0,
    ST_SST  = 3'h1,
    ST_OPT  = 3'h2,
    ST_RUN  = 3'h3,
    ST_HALT = 3'h4
  } hwr_state_t;

  typedef enum logic [1:0] {
    RESUME_START = 2'h0,
    RESUME_NEXT  = 2'h1,
    RESUME_IRQ   = 2'h2
  } hwr_resume_t;

endpackage

// File: rtl/hwr_sync.sv
`timescale 1ns/1ps
module hwr_sync #(
  parameter int          W        = 1,
  parameter logic [W-1:0] INIT    = '1
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  // asynchronous level and its synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule

// File: rtl/hwr_ctrl.sv
`timescale 1ns/1ps
module hwr_ctrl
  import hwr_pkg::*;
#(
  parameter int PORT_W = hwr_pkg::PORT_A_W
) (
  // clock and power-up reset
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  // pins
  input  wire logic              ext_init_pin_n_in,
  input  wire logic [PORT_W-1:0] port_a_data_in,
  // options
  input  wire logic [PORT_W-1:0] port_a_wake_en_in,
  input  wire logic              watchdog_osc_sel_in,
  // core and watchdog events
  input  wire logic              halt_op_in,
  input  wire logic              watchdog_clear_op_in,
  input  wire logic              watchdog_overflow_in,
  // interrupt state from the core
  input  wire logic [hwr_pkg::IRQ_W-1:0] irq_flags_in,
  input  wire logic [hwr_pkg::IRQ_W-1:0] irq_enable_in,
  input  wire logic              irq_master_in,
  input  wire logic              stack_full_in,
  // clocks and holds
  output logic                   sys_osc_run_out,
  output logic                   watchdog_osc_run_out,
  output logic                   core_hold_out,
  output logic                   reg_hold_out,
  output logic                   port_hold_out,
  // reset controls
  output logic                   full_reset_out,
  output logic                   warm_reset_out,
  output logic                   option_load_out,
  output logic                   watchdog_clear_out,
  // resume and status
  output logic                   resume_out,
  output hwr_pkg::hwr_resume_t   resume_kind_out,
  output logic                   timeout_flag_out,
  output logic                   power_down_flag_out
);
  import hwr_pkg::*;

  logic              pin_n_sync;
  logic [PORT_W-1:0] port_sync;

  hwr_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (ext_init_pin_n_in),
    .sync_out   (pin_n_sync)
  );

  hwr_sync #(.W(PORT_W), .INIT({PORT_W{1'b1}})) u_port_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (port_a_data_in),
    .sync_out   (port_sync)
  );

  hwr_state_t                  state;
  hwr_state_t                  next_state;
  logic [CNT_W-1:0]            count;
  logic [CNT_W-1:0]            next_count;
  logic                        full;
  logic                        next_full;
  hwr_resume_t                 kind;
  hwr_resume_t                 next_kind;
  logic                        to_flag;
  logic                        next_to_flag;
  logic                        pd_flag;
  logic                        next_pd_flag;
  logic [IRQ_W-1:0]            irq_snap;
  logic [IRQ_W-1:0]            next_irq_snap;
  logic [PORT_W-1:0]           port_prev;
  logic                        fall_seen;
  logic                        next_fall_seen;
  logic                        next_warm;
  logic                        next_resume;
  logic                        next_wdt_clear;
  logic [IRQ_W-1:0]            irq_new;
  logic                        fall_now;
  logic                        halt_entry;

  // only requests raised after halt entry may wake
  assign irq_new    = irq_flags_in & ~irq_snap;
  assign fall_now   = |(port_prev & ~port_sync & port_a_wake_en_in);
  assign halt_entry = (state == ST_RUN) && pin_n_sync && !watchdog_overflow_in && halt_op_in;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_full      = full;
    next_kind      = kind;
    next_to_flag   = to_flag;
    next_pd_flag   = pd_flag;
    next_irq_snap  = irq_snap;
    next_warm      = 1'b0;
    next_resume    = 1'b0;
    next_wdt_clear = 1'b0;
    // a fall in the same cycle as halt entry is kept: set wins over clear
    next_fall_seen = fall_now | (fall_seen & !halt_entry);
    case (state)
      ST_PIN: begin
        // full reset is held for as long as the pin stays low
        next_count = CNT_ZERO;
        if (pin_n_sync) begin
          next_state = ST_SST;
        end
      end
      ST_SST: begin
        next_count = count + 11'h001;
        if (count == SST_LAST) begin
          next_count = CNT_ZERO;
          if (full) begin
            next_state = ST_OPT;
          end else begin
            next_state  = ST_RUN;
            next_resume = 1'b1;
          end
        end
      end
      ST_OPT: begin
        next_count = count + 11'h001;
        if (count == OPT_LAST) begin
          next_count  = CNT_ZERO;
          next_state  = ST_RUN;
          next_full   = 1'b0;
          next_resume = 1'b1;
          next_kind   = RESUME_START;
        end
      end
      ST_RUN: begin
        if (!pin_n_sync) begin
          // flags stay as they are for a pin reset in normal run
          next_state = ST_PIN;
          next_full  = 1'b1;
          next_kind  = RESUME_START;
        end else if (watchdog_overflow_in) begin
          next_state   = ST_SST;
          next_count   = CNT_ZERO;
          next_full    = 1'b1;
          next_to_flag = 1'b1;
          next_kind    = RESUME_START;
        end else if (halt_op_in) begin
          next_state     = ST_HALT;
          next_pd_flag   = 1'b1;
          next_to_flag   = 1'b0;
          next_irq_snap  = irq_flags_in;
          next_wdt_clear = watchdog_osc_sel_in;
        end else if (watchdog_clear_op_in) begin
          next_pd_flag   = 1'b0;
          next_wdt_clear = 1'b1;
        end
      end
      ST_HALT: begin
        next_count = CNT_ZERO;
        if (!pin_n_sync) begin
          next_state   = ST_PIN;
          next_full    = 1'b1;
          next_to_flag = 1'b0;
          next_pd_flag = 1'b1;
          next_kind    = RESUME_START;
        end else if (watchdog_overflow_in) begin
          // warm reset: only PC and stack pointer, no option load
          next_state   = ST_SST;
          next_warm    = 1'b1;
          next_to_flag = 1'b1;
          next_pd_flag = 1'b1;
          next_kind    = RESUME_START;
        end else if (|irq_new) begin
          next_state = ST_SST;
          if (irq_master_in && |(irq_new & irq_enable_in) && !stack_full_in) begin
            next_kind = RESUME_IRQ;
          end else begin
            next_kind = RESUME_NEXT;
          end
        end else if (fall_seen) begin
          next_state = ST_SST;
          next_kind  = RESUME_NEXT;
        end
      end
      default: begin
        next_state = ST_SST;
        next_count = CNT_ZERO;
        next_full  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      // power-up: full reset then start-up and option delays
      state                <= ST_SST;
      count                <= CNT_ZERO;
      full                 <= 1'b1;
      kind                 <= RESUME_START;
      to_flag              <= 1'b0;
      pd_flag              <= 1'b0;
      irq_snap             <= '0;
      port_prev            <= '1;
      fall_seen            <= 1'b0;
      sys_osc_run_out      <= 1'b1;
      watchdog_osc_run_out <= 1'b1;
      core_hold_out        <= 1'b1;
      reg_hold_out         <= 1'b0;
      port_hold_out        <= 1'b0;
      full_reset_out       <= 1'b1;
      warm_reset_out       <= 1'b0;
      option_load_out      <= 1'b0;
      watchdog_clear_out   <= 1'b1;
      resume_out           <= 1'b0;
      resume_kind_out      <= RESUME_START;
      timeout_flag_out     <= 1'b0;
      power_down_flag_out  <= 1'b0;
    end else begin
      state                <= next_state;
      count                <= next_count;
      full                 <= next_full;
      kind                 <= next_kind;
      to_flag              <= next_to_flag;
      pd_flag              <= next_pd_flag;
      irq_snap             <= next_irq_snap;
      port_prev            <= port_sync;
      fall_seen            <= next_fall_seen;
      sys_osc_run_out      <= (next_state != ST_HALT);
      watchdog_osc_run_out <= (next_state != ST_HALT) || watchdog_osc_sel_in;
      core_hold_out        <= (next_state != ST_RUN);
      reg_hold_out         <= (next_state == ST_HALT);
      port_hold_out        <= (next_state == ST_HALT);
      // core loads the package reset values while this is high
      full_reset_out       <= next_full;
      warm_reset_out       <= next_warm;
      option_load_out      <= (next_state == ST_OPT);
      watchdog_clear_out   <= next_wdt_clear | next_full;
      resume_out           <= next_resume;
      resume_kind_out      <= next_kind;
      timeout_flag_out     <= next_to_flag;
      power_down_flag_out  <= next_pd_flag;
    end
  end

  // checks
  AST_HALT_FLAGS: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    halt_entry |=> power_down_flag_out && !timeout_flag_out && state == ST_HALT)
    else $error("halt entry did not set power-down and clear timeout");

  AST_OSC_STOP: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_HALT |-> !sys_osc_run_out && (watchdog_osc_run_out == watchdog_osc_sel_in || $past(state) != ST_HALT))
    else $error("oscillator controls wrong during power-down");

  AST_WDT_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    halt_entry && watchdog_osc_sel_in |=> watchdog_clear_out ##1 !watchdog_clear_out)
    else $error("watchdog not cleared once at power-down entry");

  AST_HOLDS: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $past(state) == ST_HALT && state == ST_HALT |-> port_hold_out && reg_hold_out && core_hold_out)
    else $error("ports or registers not held during power-down");

  AST_PIN_IN_HALT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_HALT && !pin_n_sync |=> full_reset_out && power_down_flag_out && !timeout_flag_out)
    else $error("pin reset in power-down did not give full reset with flags 0,1");

  AST_WARM: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_HALT && pin_n_sync && watchdog_overflow_in
      |=> warm_reset_out && !full_reset_out && timeout_flag_out && power_down_flag_out)
    else $error("watchdog wake did not warm reset with flags 1,1");

  AST_RUN_WDT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_RUN && pin_n_sync && watchdog_overflow_in
      |=> full_reset_out && timeout_flag_out && power_down_flag_out == $past(power_down_flag_out))
    else $error("normal watchdog overflow did not full reset");

  AST_PDF_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_RUN && pin_n_sync && !watchdog_overflow_in && !halt_op_in && watchdog_clear_op_in
      |=> !power_down_flag_out)
    else $error("watchdog clear did not clear power-down flag");

  AST_SST_DONE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    resume_out |-> ($past(state) == ST_SST && $past(count) == SST_LAST) ||
                   ($past(state) == ST_OPT && $past(count) == OPT_LAST))
    else $error("resume without completed start-up delay");

  AST_OLD_IRQ: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_HALT && pin_n_sync && !watchdog_overflow_in && irq_flags_in == irq_snap && !fall_seen
      |=> state == ST_HALT)
    else $error("stale interrupt woke the device");

  AST_PORT_WAKE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state == ST_HALT && pin_n_sync && !watchdog_overflow_in && irq_new == '0 && fall_seen
      |=> state == ST_SST && resume_kind_out == RESUME_NEXT)
    else $error("port wake did not resume at next instruction");

  AST_POWER_UP: assert property (@(posedge clock_in)
    $rose(reset_n_in) |-> !timeout_flag_out && !power_down_flag_out && full_reset_out)
    else $error("power-up flags not 0,0");

endmodule

// File: testbench/hwr_core_model.sv
`timescale 1ns/1ps
module hwr_core_model (
  // clock and hold from the sequencer
  input  wire logic clock_in,
  input  wire logic core_hold_in,
  // instruction strobes towards the sequencer
  output logic      halt_op_out,
  output logic      clear_op_out
);
  initial begin
    halt_op_out  = 1'b0;
    clear_op_out = 1'b0;
  end

  // a held core issues nothing, so wait for release before the strobe
  task automatic issue(input bit halt);
    int n;
    n = 0;
    while (core_hold_in !== 1'b0 && n < 3000) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    halt_op_out  = halt;
    clear_op_out = !halt;
    @(posedge clock_in);
    #1;
    halt_op_out  = 1'b0;
    clear_op_out = 1'b0;
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hwr_pkg::*;
  logic        clock_in   = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        pin_n      = 1'b1;
  logic [7:0]  pa         = 8'hff;
  logic [7:0]  pa_en      = 8'h00;
  logic        wd_sel     = 1'b1;
  logic        wd_ovf     = 1'b0;
  logic [2:0]  irq_f      = 3'h0;
  logic [2:0]  irq_e      = 3'h7;
  logic        irq_m      = 1'b0;
  logic        stk_full   = 1'b0;
  logic        halt_op, clr_op, osc_run, wd_run, core_hold, reg_hold, port_hold;
  logic        full_rst, warm_rst, opt_load, wd_clr, resume, to_flag, pd_flag;
  hwr_resume_t kind;
  logic [7:0]  lfsr_q     = 8'h33;
  int          fails      = 0;
  int          tests_run  = 0;
  int          m_to       = 0;
  int          m_pdf      = 0;
  int          warm_cnt   = 0;
  int          opt_cnt    = 0;
  int          a, b;

  always #2.5 clock_in = ~clock_in;

  hwr_core_model u_core (.clock_in(clock_in), .core_hold_in(core_hold), .halt_op_out(halt_op),
                         .clear_op_out(clr_op));

  hwr_ctrl u_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .ext_init_pin_n_in(pin_n), .port_a_data_in(pa),
    .port_a_wake_en_in(pa_en), .watchdog_osc_sel_in(wd_sel), .halt_op_in(halt_op),
    .watchdog_clear_op_in(clr_op), .watchdog_overflow_in(wd_ovf), .irq_flags_in(irq_f),
    .irq_enable_in(irq_e), .irq_master_in(irq_m), .stack_full_in(stk_full), .sys_osc_run_out(osc_run),
    .watchdog_osc_run_out(wd_run), .core_hold_out(core_hold), .reg_hold_out(reg_hold),
    .port_hold_out(port_hold), .full_reset_out(full_rst), .warm_reset_out(warm_rst),
    .option_load_out(opt_load), .watchdog_clear_out(wd_clr), .resume_out(resume),
    .resume_kind_out(kind), .timeout_flag_out(to_flag), .power_down_flag_out(pd_flag));

  // pulses are counted on the edge after they land, clear of the update race
  always @(posedge clock_in) begin
    if (warm_rst === 1'b1) warm_cnt++;
    if (opt_load === 1'b1) opt_cnt++;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_kind(input logic [1:0] exp);
    tests_run++;
    if (kind !== exp) begin
      fails++;
      $display("[ERR] resume_kind expected %0d seen %0d", exp, kind);
    end
  endtask

  task automatic cmp_cnt(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmp_flags();
    tests_run++;
    if ({to_flag, pd_flag} !== {m_to[0], m_pdf[0]}) begin
      fails++;
      $display("[ERR] flags expected %0d%0d seen %b%b", m_to, m_pdf, to_flag, pd_flag);
    end
  endtask

  task automatic wait_resume(output int n);
    n = 0;
    while (resume !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
  endtask

  task automatic do_halt();
    logic c;
    u_core.issue(1'b1);
    c = wd_clr;
    step(1);
    c = c | wd_clr;
    m_pdf = 1;
    m_to  = 0;
    cmp_flags();
    cmp_bit("osc_run", 1'b0, osc_run);
    cmp_bit("wd_osc_run", wd_sel, wd_run);
    cmp_bit("wd_clear", wd_sel, c);
    cmp_bit("reg_hold", 1'b1, reg_hold);
    cmp_bit("port_hold", 1'b1, port_hold);
  endtask

  task automatic wake_chk(input logic [1:0] k);
    int n;
    n = 0;
    while (osc_run !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    cmp_bit("port_hold", 1'b0, port_hold);
    wait_resume(n);
    cmp_cnt("wake_delay", SST_CYCLES, n);
    cmp_bit("core_hold", 1'b0, core_hold);
    cmp_kind(k);
    cmp_flags();
  endtask

  // extra: edges before the count starts (pin synchroniser), negative if already spent
  task automatic full_chk(input int extra);
    int n;
    opt_cnt = 0;
    wait_resume(n);
    cmp_cnt("reset_len", SST_CYCLES + OPT_LOAD_CYCLES + extra, n);
    cmp_cnt("opt_cycles", OPT_LOAD_CYCLES, opt_cnt);
    cmp_bit("core_hold", 1'b0, core_hold);
    cmp_kind(RESUME_START);
    cmp_flags();
  endtask

  task automatic pin_pulse();
    pin_n = 1'b0;
    step(5);
    cmp_bit("full_reset", 1'b1, full_rst);
    cmp_flags();
    pin_n = 1'b1;
    full_chk(3);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // about 9.5k cycles of work expected; allow over three times that
  initial begin
    #(5 * 30000);
    fails++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clock_in);
    #1;
    reset_n_in = 1'b1;
    full_chk(0);
    $display("test power_up done");
    for (int i = 0; i < 3; i++) begin
      lfsr_q   = lfsr_next(lfsr_q);
      a        = lfsr_q % 3;
      b        = (a + 1) % 3;
      wd_sel   = (i != 2);
      irq_m    = (i != 2);
      stk_full = (i == 1);
      irq_f    = 3'h1 << a;
      do_halt();
      step(40);
      cmp_bit("osc_run", 1'b0, osc_run);
      irq_f[b] = 1'b1;
      wake_chk((i == 0) ? RESUME_IRQ : RESUME_NEXT);
      irq_f = 3'h0;
      $display("test irq_wake %0d done", i);
    end
    wd_sel = 1'b1;
    lfsr_q = lfsr_next(lfsr_q);
    a      = lfsr_q[2:0];
    b      = a ^ 4;
    pa_en  = (lfsr_q | (8'h01 << a)) & ~(8'h01 << b);
    do_halt();
    pa[b] = 1'b0;
    step(40);
    cmp_bit("osc_run", 1'b0, osc_run);
    pa[b] = 1'b1;
    step(4);
    pa[a] = 1'b0;
    wake_chk(RESUME_NEXT);
    pa = 8'hff;
    $display("test port_wake done");
    u_core.issue(1'b0);
    step(1);
    m_pdf = 0;
    cmp_flags();
    do_halt();
    warm_cnt = 0;
    opt_cnt  = 0;
    wd_ovf   = 1'b1;
    step(1);
    wd_ovf = 1'b0;
    m_to   = 1;
    wake_chk(RESUME_START);
    cmp_cnt("warm_pulses", 1, warm_cnt);
    cmp_cnt("opt_cycles", 0, opt_cnt);
    $display("test wdt_halt done");
    wd_ovf = 1'b1;
    step(1);
    wd_ovf = 1'b0;
    step(1);
    cmp_bit("full_reset", 1'b1, full_rst);
    full_chk(-1);
    $display("test wdt_run done");
    pin_pulse();
    $display("test pin_run done");
    do_halt();
    pin_pulse();
    $display("test pin_halt done");
    end_sim();
  end
endmodule
